// ===== design/csbd_alu.sv
`timescale 1ns/1ps
module csbd_alu (
    input wire csbd_pkg::csbd_op_t op,
    input wire logic [7:0] f_val,
    input wire logic [7:0] w_val,
    input wire csbd_pkg::csbd_status_t st_in,
    output logic [7:0] result,
    output csbd_pkg::csbd_status_t st_out,
    output logic greater
);

    logic [8:0] cmp_diff;
    logic [8:0] daw_low;
    logic [8:0] daw_full;
    logic low_fix;
    logic high_fix;
    logic [7:0] dec_res;

    // Unsigned subtraction; a borrow out means f exceeds W.
    assign cmp_diff = {1'h0, w_val} - {1'h0, f_val};
    assign greater = (op == csbd_pkg::CSBD_OP_CMP) && cmp_diff[8];

    // The low correction may carry into the high nibble, so the high test looks at the
    // already corrected value.
    assign low_fix = (w_val[3:0] > csbd_pkg::BCD_MAX_DIGIT) || st_in.digit_carry_flag;
    assign daw_low = {1'h0, w_val} + (low_fix ? csbd_pkg::BCD_LOW_FIX : 9'h000);
    assign high_fix = (daw_low[7:4] > csbd_pkg::BCD_MAX_DIGIT) || st_in.carry
                      || daw_low[8];
    assign daw_full = {1'h0, daw_low[7:0]} + (high_fix ? csbd_pkg::BCD_HIGH_FIX : 9'h000);

    assign dec_res = f_val - csbd_pkg::ONE_BYTE;

    always_comb begin
        result = w_val;
        st_out = st_in;
        unique case (op)
            csbd_pkg::CSBD_OP_DAW: begin
                result = daw_full[7:0];
                st_out.carry = st_in.carry | daw_low[8] | daw_full[8];
            end
            csbd_pkg::CSBD_OP_DEC: begin
                result = dec_res;
                st_out.carry = (f_val != csbd_pkg::ZERO_BYTE);
                st_out.digit_carry_flag = (f_val[3:0] != csbd_pkg::ZERO_NIBBLE);
                st_out.negative = dec_res[7];
                st_out.overflow_flag = (f_val == csbd_pkg::MIN_NEG_BYTE);
                st_out.zero = (dec_res == csbd_pkg::ZERO_BYTE);
            end
            csbd_pkg::CSBD_OP_CMP: begin
                result = f_val;
            end
            csbd_pkg::CSBD_OP_NOP: begin
                result = w_val;
            end
        endcase
    end

endmodule : csbd_alu

// ===== design/csbd_exec.sv
`timescale 1ns/1ps
module csbd_exec (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic instr_valid,
    input wire logic [15:0] instr_word,
    input wire logic instr_two_word,
    input wire logic [3:0] bank_select_reg,
    input wire logic [7:0] mem_rd_data,
    input wire csbd_pkg::csbd_load_t core_load,
    output logic instr_ready_q,
    output logic mem_rd_en_q,
    output logic [11:0] mem_addr_q,
    output logic mem_wr_en_q,
    output logic [7:0] mem_wr_data_q,
    output logic [7:0] working_register_q,
    output csbd_pkg::csbd_status_t status_q,
    output logic exec_done_q,
    output logic squashed_q
);

    // ------------------------------------------------------------------
    // Phase sequencer
    // ------------------------------------------------------------------
    csbd_pkg::csbd_phase_t phase_q;
    csbd_pkg::csbd_phase_t phase_d;
    logic take;

    assign take = (phase_q == csbd_pkg::CSBD_Q1) && instr_valid;

    always_comb begin
        phase_d = phase_q;
        unique case (phase_q)
            csbd_pkg::CSBD_Q1: begin
                if (take) begin
                    phase_d = csbd_pkg::CSBD_Q2;
                end
            end
            csbd_pkg::CSBD_Q2: begin
                phase_d = csbd_pkg::CSBD_Q3;
            end
            csbd_pkg::CSBD_Q3: begin
                phase_d = csbd_pkg::CSBD_Q4;
            end
            csbd_pkg::CSBD_Q4: begin
                phase_d = csbd_pkg::CSBD_Q1;
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            phase_q <= csbd_pkg::CSBD_Q1;
            instr_ready_q <= 1'h1;
        end else begin
            phase_q <= phase_d;
            instr_ready_q <= (phase_d == csbd_pkg::CSBD_Q1);
        end
    end

    // ------------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------------
    csbd_pkg::csbd_op_t dec_op;
    csbd_pkg::csbd_op_t op_q;
    logic dest_file_q;
    logic [1:0] flush_q;
    logic [1:0] flush_d;
    logic skip_set;
    logic [3:0] bank_sel;

    always_comb begin
        dec_op = csbd_pkg::CSBD_OP_NOP;
        if (instr_word[15:9] == csbd_pkg::CPF_GT_PREFIX) begin
            dec_op = csbd_pkg::CSBD_OP_CMP;
        end else if (instr_word == csbd_pkg::DAW_OPCODE) begin
            dec_op = csbd_pkg::CSBD_OP_DAW;
        end else if (instr_word[15:10] == csbd_pkg::DEC_PREFIX) begin
            dec_op = csbd_pkg::CSBD_OP_DEC;
        end
    end

    // The access bank splits its 256 bytes between the lowest and the highest bank.
    always_comb begin
        if (instr_word[csbd_pkg::ABIT_POS] == csbd_pkg::ABIT_ACCESS) begin
            if (instr_word[csbd_pkg::FADDR_MSB:0] < csbd_pkg::ACCESS_SPLIT) begin
                bank_sel = csbd_pkg::ACCESS_LOW_BANK;
            end else begin
                bank_sel = csbd_pkg::ACCESS_HIGH_BANK;
            end
        end else begin
            bank_sel = bank_select_reg;
        end
    end

    // A squashed word that announces a second word keeps the squash armed for one
    // more fetch, so the skip squashes two words, eight clock cycles in all.
    always_comb begin
        flush_d = flush_q;
        if (take && (flush_q != 2'h0)) begin
            if ((flush_q == 2'h1) && instr_two_word) begin
                flush_d = 2'h2;
            end else begin
                flush_d = 2'h0;
            end
        end
        if (skip_set) begin
            flush_d = 2'h1;
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            flush_q <= 2'h0;
        end else begin
            flush_q <= flush_d;
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            op_q <= csbd_pkg::CSBD_OP_NOP;
            dest_file_q <= 1'h0;
            squashed_q <= 1'h0;
        end else if (take) begin
            if (flush_q != 2'h0) begin
                op_q <= csbd_pkg::CSBD_OP_NOP;
                squashed_q <= 1'h1;
            end else begin
                op_q <= dec_op;
                squashed_q <= 1'h0;
            end
            dest_file_q <= (instr_word[csbd_pkg::DBIT_POS] != csbd_pkg::DBIT_WORKING_REGISTER);
        end
    end

    // ------------------------------------------------------------------
    // Data memory access
    // ------------------------------------------------------------------
    logic needs_read;

    assign needs_read = (flush_q == 2'h0)
                        && ((dec_op == csbd_pkg::CSBD_OP_CMP) || (dec_op == csbd_pkg::CSBD_OP_DEC));

    // The read strobe covers the second phase; the memory answers in the third.
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            mem_rd_en_q <= 1'h0;
            mem_addr_q <= 12'h000;
        end else begin
            mem_rd_en_q <= take && needs_read;
            if (take) begin
                mem_addr_q <= {bank_sel, instr_word[csbd_pkg::FADDR_MSB:0]};
            end
        end
    end

    // ------------------------------------------------------------------
    // Execute
    // ------------------------------------------------------------------
    logic [7:0] alu_result;
    csbd_pkg::csbd_status_t alu_status;
    logic alu_greater;
    logic exec_edge;

    assign exec_edge = (phase_q == csbd_pkg::CSBD_Q3);
    assign skip_set = exec_edge && alu_greater;

    csbd_alu u_alu (
        .op(op_q),
        .f_val(mem_rd_data),
        .w_val(working_register_q),
        .st_in(status_q),
        .result(alu_result),
        .st_out(alu_status),
        .greater(alu_greater)
    );

    // Results land at the end of the third phase so the write strobe can stand in
    // the fourth straight from a flop.
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            working_register_q <= csbd_pkg::ZERO_BYTE;
        end else if (exec_edge && (op_q == csbd_pkg::CSBD_OP_DAW)) begin
            working_register_q <= alu_result;
        end else if (exec_edge && (op_q == csbd_pkg::CSBD_OP_DEC) && !dest_file_q) begin
            working_register_q <= alu_result;
        end else if ((phase_q == csbd_pkg::CSBD_Q1) && core_load.w_we) begin
            working_register_q <= core_load.w_data;
        end
    end

    // The compare leaves every flag alone; only decrement and adjust touch them.
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            status_q <= csbd_pkg::STATUS_RESET;
        end else if (exec_edge && ((op_q == csbd_pkg::CSBD_OP_DAW)
                                   || (op_q == csbd_pkg::CSBD_OP_DEC))) begin
            status_q <= alu_status;
        end else if ((phase_q == csbd_pkg::CSBD_Q1) && core_load.st_we) begin
            status_q <= core_load.st_data;
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            mem_wr_en_q <= 1'h0;
            mem_wr_data_q <= csbd_pkg::ZERO_BYTE;
        end else begin
            mem_wr_en_q <= exec_edge && (op_q == csbd_pkg::CSBD_OP_DEC) && dest_file_q;
            if (exec_edge) begin
                mem_wr_data_q <= alu_result;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            exec_done_q <= 1'h0;
        end else begin
            exec_done_q <= exec_edge;
        end
    end

endmodule : csbd_exec

// ===== design/csbd_pkg.sv
package csbd_pkg;

    // ------------------------------------------------------------------
    // Instruction fields
    // ------------------------------------------------------------------
    localparam int unsigned INSTR_W = 16;
    localparam int unsigned DATA_W = 8;
    localparam int unsigned BANK_W = 4;
    localparam int unsigned ADDR_W = 12;
    localparam int unsigned ABIT_POS = 8;
    localparam int unsigned DBIT_POS = 9;
    localparam int unsigned FADDR_MSB = 7;

    localparam logic [6:0] CPF_GT_PREFIX = 7'h32;
    localparam logic [5:0] DEC_PREFIX = 6'h01;
    localparam logic [15:0] DAW_OPCODE = 16'h0007;

    // Bank bit and destination bit meanings.
    localparam logic ABIT_ACCESS = 1'h0;
    localparam logic DBIT_WORKING_REGISTER = 1'h0;

    // ------------------------------------------------------------------
    // Access bank layout
    // ------------------------------------------------------------------
    localparam logic [7:0] ACCESS_SPLIT = 8'h80;
    localparam logic [3:0] ACCESS_LOW_BANK = 4'h0;
    localparam logic [3:0] ACCESS_HIGH_BANK = 4'hF;

    // ------------------------------------------------------------------
    // Arithmetic constants
    // ------------------------------------------------------------------
    localparam logic [3:0] BCD_MAX_DIGIT = 4'h9;
    localparam logic [8:0] BCD_LOW_FIX = 9'h006;
    localparam logic [8:0] BCD_HIGH_FIX = 9'h060;
    localparam logic [7:0] ONE_BYTE = 8'h01;
    localparam logic [7:0] MIN_NEG_BYTE = 8'h80;
    localparam logic [7:0] ZERO_BYTE = 8'h00;
    localparam logic [3:0] ZERO_NIBBLE = 4'h0;

    // ------------------------------------------------------------------
    // Types
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        CSBD_Q1 = 2'h0,
        CSBD_Q2 = 2'h1,
        CSBD_Q3 = 2'h3,
        CSBD_Q4 = 2'h2
    } csbd_phase_t;

    typedef enum logic [1:0] {
        CSBD_OP_NOP = 2'h0,
        CSBD_OP_CMP = 2'h1,
        CSBD_OP_DAW = 2'h2,
        CSBD_OP_DEC = 2'h3
    } csbd_op_t;

    typedef struct packed {
        logic negative;
        logic overflow_flag;
        logic zero;
        logic digit_carry_flag;
        logic carry;
    } csbd_status_t;

    localparam csbd_status_t STATUS_RESET = '{default: 1'h0};

    typedef struct packed {
        logic w_we;
        logic [7:0] w_data;
        logic st_we;
        csbd_status_t st_data;
    } csbd_load_t;

endpackage : csbd_pkg

// ===== test/csbd_data_mem.sv
`timescale 1ns/1ps
module csbd_data_mem (
    input wire logic clk_sys,
    input wire logic rd_en,
    input wire logic wr_en,
    input wire logic [11:0] addr,
    input wire logic [7:0] wr_data,
    output logic [7:0] rd_data
);
    logic [7:0] mem [0:4095];
    initial begin
        rd_data = 8'h00;
        for (int i = 0; i < 4096; i++) mem[i] = 8'h00;
    end
    // Data is valid only in the read slot; elsewhere it toggles so late sampling shows up.
    always @(posedge clk_sys) begin
        if (rd_en) begin
            rd_data <= mem[addr];
        end else begin
            rd_data <= ~rd_data;
        end
        if (wr_en) begin
            mem[addr] <= wr_data;
        end
    end
endmodule : csbd_data_mem

// ===== test/csbd_exec_sva.sv
`timescale 1ns/1ps
module csbd_exec_sva (
    input wire logic clk_sys,
    input wire logic nrst,
    input wire logic instr_valid,
    input wire logic [15:0] instr_word,
    input wire logic [3:0] bank_select_reg,
    input wire logic [7:0] mem_rd_data,
    input wire logic instr_ready_q,
    input wire logic mem_rd_en_q,
    input wire logic [11:0] mem_addr_q,
    input wire logic mem_wr_en_q,
    input wire logic [7:0] mem_wr_data_q,
    input wire logic [7:0] working_register_q,
    input wire csbd_pkg::csbd_status_t status_q,
    input wire logic exec_done_q,
    input wire logic squashed_q
);
    // ------------------------------------------------------------------
    // Word and bank captured at take
    // ------------------------------------------------------------------
    logic take;
    logic [15:0] word_q;
    logic [3:0] bank_q;
    assign take = instr_valid && instr_ready_q;
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            word_q <= 16'h0000;
            bank_q <= 4'h0;
        end else if (take) begin
            word_q <= instr_word;
            bank_q <= bank_select_reg;
        end
    end
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!nrst);
    a_ready_busy: assert property (
        take |=> !instr_ready_q [*3] ##1 instr_ready_q) else $error("ready timing wrong");
    a_done_slot: assert property (
        take |-> ##3 exec_done_q) else $error("done not in fourth cycle");
    a_adjust_noread: assert property (
        take && instr_word == csbd_pkg::DAW_OPCODE |=> (!mem_rd_en_q && !mem_wr_en_q) [*3])
        else $error("adjust touched memory");
    a_cmp_quiet: assert property (
        take && instr_word[15:9] == csbd_pkg::CPF_GT_PREFIX |=>
        (!mem_wr_en_q && $stable(status_q) && $stable(working_register_q)) [*3])
        else $error("compare changed state");
    a_access_bank: assert property (
        mem_rd_en_q && !word_q[8] |-> mem_addr_q == {word_q[7] ? csbd_pkg::ACCESS_HIGH_BANK :
        csbd_pkg::ACCESS_LOW_BANK, word_q[7:0]}) else $error("access bank address wrong");
    a_bank_reg: assert property (
        mem_rd_en_q && word_q[8] |-> mem_addr_q == {bank_q, word_q[7:0]})
        else $error("banked address wrong");
    a_dec_write: assert property (
        mem_wr_en_q |-> word_q[9] && mem_wr_data_q == $past(mem_rd_data) - 8'h01)
        else $error("decrement write wrong");
    a_dec_zero: assert property (
        exec_done_q && !squashed_q && word_q[15:10] == csbd_pkg::DEC_PREFIX |->
        status_q.zero == ($past(mem_rd_data) == 8'h01)) else $error("zero flag wrong");
    a_squash_quiet: assert property (
        squashed_q |-> !mem_rd_en_q && !mem_wr_en_q) else $error("squashed word accessed memory");
endmodule : csbd_exec_sva

// ===== test/testbench.sv
`timescale 1ns/1ps
module testbench;
    logic clk_sys = 1'b0;
    logic nrst = 1'b0;
    logic instr_valid = 1'b0;
    logic [15:0] instr_word = 16'h0000;
    logic instr_two_word = 1'b0;
    logic [3:0] bank_select_reg = 4'h5;
    logic [7:0] mem_rd_data;
    csbd_pkg::csbd_load_t core_load = '0;
    logic instr_ready_q, mem_rd_en_q, mem_wr_en_q, exec_done_q, squashed_q;
    logic [11:0] mem_addr_q;
    logic [7:0] mem_wr_data_q, working_register_q;
    csbd_pkg::csbd_status_t status_q;
    int mismatches = 0;
    int n_compared = 0;
    int cycles = 0;
    logic [15:0] daw_tab [5] = '{16'hA500, 16'hCE00, 16'h1902, 16'h4201, 16'h3300};
    logic [8:0] daw_exp [5] = '{9'h105, 9'h134, 9'h01F, 9'h1A2, 9'h033};
    always #2 clk_sys = ~clk_sys;
    csbd_exec u_dut (
        .clk_sys(clk_sys),
        .nrst(nrst),
        .instr_valid(instr_valid),
        .instr_word(instr_word),
        .instr_two_word(instr_two_word),
        .bank_select_reg(bank_select_reg),
        .mem_rd_data(mem_rd_data),
        .core_load(core_load),
        .instr_ready_q(instr_ready_q),
        .mem_rd_en_q(mem_rd_en_q),
        .mem_addr_q(mem_addr_q),
        .mem_wr_en_q(mem_wr_en_q),
        .mem_wr_data_q(mem_wr_data_q),
        .working_register_q(working_register_q),
        .status_q(status_q),
        .exec_done_q(exec_done_q),
        .squashed_q(squashed_q)
    );
    csbd_data_mem u_mem (.clk_sys, .rd_en(mem_rd_en_q), .wr_en(mem_wr_en_q), .addr(mem_addr_q),
        .wr_data(mem_wr_data_q), .rd_data(mem_rd_data));
    // ------------------------------------------------------------------
    // Access tasks
    // ------------------------------------------------------------------
    task automatic check(input logic [8:0] seen, input logic [8:0] exp);
        n_compared++;
        if (seen !== exp) begin
            mismatches++;
            $display("unexpected at %0t: got %h, want %h", $time, seen, exp);
        end
    endtask : check
    task automatic report_and_stop();
        $display("compared %0d, mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : report_and_stop
    // Returns at the edge after the done pulse, so the next word can go back to back.
    task automatic run(input logic [15:0] w, input logic two);
        int i;
        instr_word <= w;
        instr_two_word <= two;
        instr_valid <= 1'b1;
        @(posedge clk_sys);
        while (instr_ready_q !== 1'b1) @(posedge clk_sys);
        instr_valid <= 1'b0;
        i = 0;
        do begin
            @(posedge clk_sys);
            i++;
        end while (exec_done_q !== 1'b1 && i < 8);
        check({8'h00, i == 3}, 9'h001);
    endtask : run
    task automatic load(input logic [7:0] w, input logic [4:0] st);
        core_load <= '{w_we: 1'b1, w_data: w, st_we: 1'b1, st_data: st};
        repeat (2) @(posedge clk_sys);
        core_load <= '0;
        @(posedge clk_sys);
    endtask : load
    function automatic logic [15:0] dec(input logic d, input logic a, input logic [7:0] f);
        return {csbd_pkg::DEC_PREFIX, d, a, f};
    endfunction : dec
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            mismatches++;
            report_and_stop();
        end
    end
    initial begin
        repeat (6) @(posedge clk_sys);
        nrst <= 1'b1;
        @(posedge clk_sys);
        u_mem.mem[12'h510] = 8'h01;
        u_mem.mem[12'hF90] = 8'h80;
        u_mem.mem[12'h530] = 8'h41;
        u_mem.mem[12'h531] = 8'h07;
        u_mem.mem[12'h532] = 8'h40;
        run(dec(1'b1, 1'b1, 8'h10), 1'b0);
        check({4'h0, status_q}, 9'h007);
        run(dec(1'b0, 1'b0, 8'h90), 1'b0);
        check({4'h0, status_q}, 9'h009);
        check({1'b0, working_register_q}, 9'h07F);
        run(dec(1'b1, 1'b0, 8'h20), 1'b0);
        check({4'h0, status_q}, 9'h010);
        @(posedge clk_sys);
        check({1'b0, u_mem.mem[12'h510]}, 9'h000);
        check({1'b0, u_mem.mem[12'hF90]}, 9'h080);
        check({1'b0, u_mem.mem[12'h020]}, 9'h0FF);
        for (int k = 0; k < 5; k++) begin
            load(daw_tab[k][15:8], {3'h0, daw_tab[k][1:0]});
            run(csbd_pkg::DAW_OPCODE, 1'b0);
            check({status_q.carry, working_register_q}, daw_exp[k]);
        end
        load(8'h40, 5'h1A);
        run({csbd_pkg::CPF_GT_PREFIX, 1'b1, 8'h30}, 1'b0);
        check({4'h0, status_q}, 9'h01A);
        check({1'b0, working_register_q}, 9'h040);
        run(dec(1'b1, 1'b1, 8'h31), 1'b0);
        check({8'h00, squashed_q}, 9'h001);
        run({csbd_pkg::CPF_GT_PREFIX, 1'b1, 8'h30}, 1'b0);
        run(dec(1'b1, 1'b1, 8'h31), 1'b1);
        run(dec(1'b1, 1'b1, 8'h31), 1'b0);
        check({8'h00, squashed_q}, 9'h001);
        run(dec(1'b1, 1'b1, 8'h31), 1'b0);
        check({8'h00, squashed_q}, 9'h000);
        run({csbd_pkg::CPF_GT_PREFIX, 1'b1, 8'h32}, 1'b0);
        run(dec(1'b1, 1'b1, 8'h31), 1'b0);
        check({8'h00, squashed_q}, 9'h000);
        @(posedge clk_sys);
        check({1'b0, u_mem.mem[12'h531]}, 9'h005);
        // A second bank value shows that the bank comes from the input and not a constant.
        bank_select_reg <= 4'h3;
        u_mem.mem[12'h310] = 8'h10;
        run(dec(1'b1, 1'b1, 8'h10), 1'b0);
        check({4'h0, status_q}, 9'h001);
        @(posedge clk_sys);
        check({1'b0, u_mem.mem[12'h310]}, 9'h00F);
        check({1'b0, u_mem.mem[12'h510]}, 9'h000);
        report_and_stop();
    end
endmodule : testbench
bind csbd_exec csbd_exec_sva u_sva (.clk_sys, .nrst, .instr_valid, .instr_word, .bank_select_reg,
    .mem_rd_data, .instr_ready_q, .mem_rd_en_q, .mem_addr_q, .mem_wr_en_q, .mem_wr_data_q,
    .working_register_q, .status_q, .exec_done_q, .squashed_q);
